// >>> inc/cbwd_pkg.sv
/*
 Package for the cell-balancing watchdog: register offset, field positions,
 reset values, prescale codes and timing counts.
 Assumes a 200 MHz system clock (mclk_in).
*/
package cbwd_pkg;
   // Register map.
   localparam logic [7:0]  ACQ_CFG_OFFSET     = 8'h0C;
   localparam logic [15:0] ACQ_CFG_RESET      = 16'h0000;
   localparam logic [11:0] BAL_EN_RESET       = 12'h000;
   localparam int          CNT_LSB            = 8;
   localparam int          CNT_MSB            = 11;
   localparam int          PSEL_LSB           = 12;
   localparam int          PSEL_MSB           = 13;
   localparam int          NUM_CELLS          = 12;
   // Prescale codes.
   localparam logic [1:0]  PSEL_OFF           = 2'h0;
   localparam logic [1:0]  PSEL_1S            = 2'h1;
   localparam logic [1:0]  PSEL_4S            = 2'h2;
   localparam logic [1:0]  PSEL_16S           = 2'h3;
   // Oscillator and tick timing.
   localparam int          CLK_HZ             = 200_000_000;
   localparam int          OSC_HZ             = 32_768;
   localparam int          OSC_HALF_CYC       = CLK_HZ / (2 * OSC_HZ);
   localparam int          OSC_PER_SEC        = OSC_HZ;
   localparam int          TICK4_DIV          = 4;
   localparam int          TICK16_DIV         = 16;
   // Start-up delay after the oscillator runs, in ns then in osc periods.
   localparam int          START_DELAY_NS     = 280_000;
   localparam int          OSC_PERIOD_NS      = 1_000_000_000 / OSC_HZ;
   localparam int          START_DELAY_OSC    = (START_DELAY_NS + OSC_PERIOD_NS - 1)
                                                / OSC_PERIOD_NS;
   // Thermal limit and hysteresis in degrees.
   localparam int          THERM_HYST_DEG     = 15;
   localparam int          THERM_LIMIT_DEG    = 145;
endpackage : cbwd_pkg

// >>> rtl/cbwd_osc_div.sv
/*
 Internal 32.768 kHz oscillator model: divides mclk_in to a one-cycle tick
 at the oscillator rate. Assumes a 200 MHz clock and synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module cbwd_osc_div
   import cbwd_pkg::*;
(
   input  wire logic mclk_in,
   input  wire logic rst_in,
   output var  logic osc_tick_out
);
   logic [12:0] half_ff;
   logic        phase_ff;

   // Two half periods make one oscillator period; a tick marks each rise.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         half_ff      <= 13'h0000;
         phase_ff     <= 1'b0;
         osc_tick_out <= 1'b0;
      end else if (half_ff == 13'(OSC_HALF_CYC - 1)) begin
         half_ff      <= 13'h0000;
         phase_ff     <= ~phase_ff;
         osc_tick_out <= ~phase_ff;
      end else begin
         half_ff      <= half_ff + 13'h0001;
         osc_tick_out <= 1'b0;
      end
   end
endmodule : cbwd_osc_div
`default_nettype wire

// >>> rtl/cbwd_prescaler.sv
/*
 Prescaler: counts oscillator ticks into 1 s, 4 s and 16 s pulses and picks
 one by the prescale select. Restarts when the timer is (re)armed.
*/
`timescale 1ns/10ps
`default_nettype none
module cbwd_prescaler
   import cbwd_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       rst_in,
   input  wire logic       osc_tick_in,
   input  wire logic       restart_in,
   input  wire logic [1:0] psel_in,
   output var  logic       tick_out
);
   logic [14:0] sec_ff;
   logic [3:0]  secs_ff;
   logic        sec_end;

   assign sec_end = osc_tick_in && (sec_ff == 15'(OSC_PER_SEC - 1));

   // Seconds divider from the 32.768 kHz oscillator.
   always_ff @(posedge mclk_in) begin
      if (rst_in || restart_in) begin
         sec_ff  <= 15'h0000;
         secs_ff <= 4'h0;
      end else if (osc_tick_in) begin
         sec_ff  <= sec_end ? 15'h0000 : sec_ff + 15'h0001;
         if (sec_end) begin
            secs_ff <= secs_ff + 4'h1;
         end
      end
   end

   // Tick selection per prescale code.
   always_ff @(posedge mclk_in) begin
      if (rst_in || restart_in) begin
         tick_out <= 1'b0;
      end else begin
         case (psel_in)
            PSEL_1S:  tick_out <= sec_end;
            PSEL_4S:  tick_out <= sec_end && (secs_ff[1:0] == 2'(TICK4_DIV - 1));
            PSEL_16S: tick_out <= sec_end && (secs_ff == 4'(TICK16_DIV - 1));
            default:  tick_out <= 1'b0;
         endcase
      end
   end
endmodule : cbwd_prescaler
`default_nettype wire

// >>> rtl/cbwd_top.sv
/*
 Cell-balancing watchdog: acquisition config timer fields, countdown,
 switch gating, reset-occurred flag and power-up / thermal sequencing.
 Assumes a serial-ladder front end that presents decoded register writes,
 an ack-slot strobe for broadcast reads, and synchronous analog status.
*/
// How it works
// [R1] A 4-bit down-counter and 2-bit prescale select live in the upper byte of register 0x0C.
// [R2] Prescale 00 stops the timer, 01 ticks each 1 s, 10 each 4 s, 11 each 16 s.
// [R3] The timeout spans 0 to 240 s from select and count.
// [R4] Writing a non-off select starts the countdown, one step per tick.
// [R5] The count is writable and reads return the value caught at the read ack slot.
// [R6] The host should rewrite the register with a nonzero count before it expires.
// [R7] A zero count while enabled holds switches off until disabled or refreshed nonzero.
// [R8] Timeout gates switches by its own path, leaving the enable register untouched.
// [R9] Arming with count already zero does not expire; only a step into zero does.
// [R10] A reset-occurred flag sets when logic power returns and stays until cleared.
// [R11] The regulator enables only with supply present, shutdown off and die not hot; the code ignores supply and shutdown in CBWD_STARTUP.
// [R12] Logic and charge pump start 280 us after the oscillator runs.
// [R13] Thermal shutdown forces switches off without altering the enable register.
// [R14] After thermal shutdown the regulator stays off until the die cools 15 degrees.
// [R15] Power-on reset returns all registers to their defaults.
// [R16] The 1, 4 and 16 s ticks are divided down from the 32.768 kHz oscillator.
`timescale 1ns/10ps
`default_nettype none
module cbwd_top
   import cbwd_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        supply_ok_in,
   input  wire logic        shutdown_input_in,
   input  wire logic [7:0]  die_temp_in,
   input  wire logic        reg_wr_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        bal_wr_in,
   input  wire logic [11:0] bal_wdata_in,
   input  wire logic        read_ack_in,
   input  wire logic        status_clr_in,
   output var  logic [15:0] acq_rdata_out,
   output var  logic [11:0] balance_switch_enables_out,
   output var  logic [11:0] switch_drive_out,
   output var  logic        timeout_out,
   output var  logic        reset_occurred_flag_out,
   output var  logic        regulator_en_out,
   output var  logic        logic_active_out,
   output var  logic        charge_pump_en_out
);
   typedef enum logic [3:0] {
      CBWD_WAIT_PWR = 4'b0001,
      CBWD_STARTUP  = 4'b0010,
      CBWD_RUN      = 4'b0100,
      CBWD_THERMAL  = 4'b1000
   } cbwd_state_t;

   cbwd_state_t state_ff;
   cbwd_state_t nxt_state;
   logic [15:0] acq_ff;
   logic [3:0]  count_ff;
   logic        expired_ff;
   logic [3:0]  nxt_count;
   logic        nxt_expired;
   logic [4:0]  start_ff;
   logic        osc_tick;
   logic        tick;
   logic        cfg_wr;
   logic        armed;
   logic        over_temp;
   logic        cooled;
   logic        therm_off;

   assign cfg_wr    = reg_wr_in && (reg_addr_in == ACQ_CFG_OFFSET);
   assign over_temp = die_temp_in > 8'(THERM_LIMIT_DEG);
   assign cooled    = die_temp_in <= 8'(THERM_LIMIT_DEG - THERM_HYST_DEG);
   assign armed     = acq_ff[PSEL_MSB:PSEL_LSB] != PSEL_OFF;
   assign therm_off = (state_ff == CBWD_THERMAL);

   // Internal oscillator.
   cbwd_osc_div u_osc (
      .mclk_in      (mclk_in),
      .rst_in       (rst_in),
      .osc_tick_out (osc_tick)
   );

   // Tick source; restarts on each config write so a refresh gets a full period.
   cbwd_prescaler u_pre (
      .mclk_in     (mclk_in),
      .rst_in      (rst_in),
      .osc_tick_in (osc_tick),
      .restart_in  (cfg_wr),
      .psel_in     (acq_ff[PSEL_MSB:PSEL_LSB]),
      .tick_out    (tick)
   ); // [R16] [R2] [R3]

   // Power-up and thermal sequencing.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         CBWD_WAIT_PWR: begin
            if (supply_ok_in && !shutdown_input_in && !over_temp) begin
               nxt_state = CBWD_STARTUP; // [R11]
            end
         end
         CBWD_STARTUP: begin
            if (over_temp) begin
               nxt_state = CBWD_THERMAL;
            end else if (start_ff == 5'(START_DELAY_OSC)) begin
               nxt_state = CBWD_RUN; // [R12]
            end
         end
         CBWD_RUN: begin
            if (over_temp) begin
               nxt_state = CBWD_THERMAL; // [R13]
            end else if (!supply_ok_in || shutdown_input_in) begin
               nxt_state = CBWD_WAIT_PWR;
            end
         end
         CBWD_THERMAL: begin
            if (cooled) begin
               nxt_state = CBWD_WAIT_PWR; // [R14]
            end
         end
         default: nxt_state = CBWD_WAIT_PWR;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state_ff <= CBWD_WAIT_PWR;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Oscillator periods counted since the regulator came up.
   always_ff @(posedge mclk_in) begin
      if (rst_in || state_ff != CBWD_STARTUP) begin
         start_ff <= 5'h00;
      end else if (osc_tick && start_ff != 5'(START_DELAY_OSC)) begin
         start_ff <= start_ff + 5'h01; // [R12]
      end
   end

   // Sequencing outputs.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         regulator_en_out   <= 1'b0;
         logic_active_out   <= 1'b0;
         charge_pump_en_out <= 1'b0;
      end else begin
         regulator_en_out   <= (nxt_state == CBWD_STARTUP) || (nxt_state == CBWD_RUN); // [R11]
         logic_active_out   <= (nxt_state == CBWD_RUN); // [R12]
         charge_pump_en_out <= (nxt_state == CBWD_RUN);
      end
   end

   // Config register; the timer count lives apart so it can step down.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         acq_ff <= ACQ_CFG_RESET; // [R15]
      end else if (cfg_wr) begin
         acq_ff <= reg_wdata_in; // [R1]
      end
   end

   // Countdown and expiry.
   always_comb begin
      nxt_count   = count_ff;
      nxt_expired = expired_ff;
      if (cfg_wr) begin
         nxt_count = reg_wdata_in[CNT_MSB:CNT_LSB]; // [R5]
         if (reg_wdata_in[PSEL_MSB:PSEL_LSB] == PSEL_OFF ||
             reg_wdata_in[CNT_MSB:CNT_LSB] != 4'h0) begin
            nxt_expired = 1'b0; // [R7]
         end
         // Arming with zero count starts no timeout; a pending one is kept. [R9]
      end else if (armed && tick && count_ff != 4'h0) begin
         nxt_count = count_ff - 4'h1; // [R4]
         if (count_ff == 4'h1) begin
            nxt_expired = 1'b1; // [R9] [R7]
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         count_ff   <= ACQ_CFG_RESET[CNT_MSB:CNT_LSB];
         expired_ff <= 1'b0; // [R15]
      end else begin
         count_ff   <= nxt_count;
         expired_ff <= nxt_expired;
      end
   end

   // Read data, with the count sampled at the broadcast read ack slot.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         acq_rdata_out <= ACQ_CFG_RESET;
      end else if (read_ack_in) begin
         acq_rdata_out <= {acq_ff[15:12], count_ff, acq_ff[7:0]}; // [R5]
      end
   end

   // Balance enables and gated switch drive.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         balance_switch_enables_out <= BAL_EN_RESET; // [R15]
         switch_drive_out           <= 12'h000;
         timeout_out                <= 1'b0;
      end else begin
         if (bal_wr_in) begin
            balance_switch_enables_out <= bal_wdata_in; // [R8]
         end
         timeout_out <= nxt_expired;
         if (nxt_expired || therm_off || over_temp || state_ff != CBWD_RUN) begin
            switch_drive_out <= 12'h000; // [R8] [R13]
         end else begin
            switch_drive_out <= bal_wr_in ? bal_wdata_in : balance_switch_enables_out;
         end
      end
   end

   // Reset-occurred flag: set on logic power return, set wins over clear.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         reset_occurred_flag_out <= 1'b0;
      end else if (nxt_state == CBWD_RUN && state_ff != CBWD_RUN) begin
         reset_occurred_flag_out <= 1'b1; // [R10]
      end else if (status_clr_in) begin
         reset_occurred_flag_out <= 1'b0;
      end
   end

   // Checks.
   expire_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      timeout_out |-> switch_drive_out == 12'h000) else $error("switches on in timeout"); // [R7]
   zero_step_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (armed && tick && count_ff == 4'h1 && !cfg_wr) |=> timeout_out)
      else $error("no expiry"); // [R9]
   // A zero-count write never starts a timeout; it keeps one only while the timer stays on.
   arm_zero_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (cfg_wr && reg_wdata_in[CNT_MSB:CNT_LSB] == 4'h0) |=>
      timeout_out == ($past(timeout_out) && armed)) else $error("arm at zero expired"); // [R9]
   bal_keep_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (!bal_wr_in) |=> $stable(balance_switch_enables_out)) else $error("enables changed"); // [R8]
   count_step_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (armed && tick && !cfg_wr && count_ff != 4'h0) |=> count_ff == $past(count_ff) - 4'h1)
      else $error("count step wrong"); // [R4]
   off_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (!armed && !cfg_wr) |=> $stable(count_ff)) else $error("count moved when off"); // [R2]
   therm_off_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      therm_off |=> !regulator_en_out && switch_drive_out == 12'h000)
      else $error("thermal not off"); // [R13]
   rst_flag_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (nxt_state == CBWD_RUN && state_ff != CBWD_RUN) |=> reset_occurred_flag_out)
      else $error("flag not set"); // [R10]
   pump_late_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      $rose(charge_pump_en_out) |-> $past(start_ff) == 5'(START_DELAY_OSC))
      else $error("pump early"); // [R12]
   read_val_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      read_ack_in |=> acq_rdata_out[11:8] == $past(count_ff)) else $error("bad read"); // [R5]
   expire_c: cover property (@(posedge mclk_in) $rose(timeout_out));
   thermal_c: cover property (@(posedge mclk_in) $rose(therm_off));
   refresh_c: cover property (@(posedge mclk_in) timeout_out ##1 cfg_wr);
endmodule : cbwd_top
`default_nettype wire

// >>> sim/cbwd_host.sv
/*
 Host controller model for the cell-balancing watchdog: register writes,
 balance enable writes, read acknowledge slots and status clears.
 Assumes the decoded register ports of cbwd_top and a free-running mclk_in.
*/
`timescale 1ns/10ps
`default_nettype none
module cbwd_host
   import cbwd_pkg::*;
(
   input  wire logic        mclk_in,
   output var  logic        reg_wr_out,
   output var  logic [7:0]  reg_addr_out,
   output var  logic [15:0] reg_wdata_out,
   output var  logic        bal_wr_out,
   output var  logic [11:0] bal_wdata_out,
   output var  logic        read_ack_out,
   output var  logic        status_clr_out
);
   // Idle at time zero with every strobe low.
   initial begin
      {reg_wr_out, bal_wr_out, read_ack_out, status_clr_out} = 4'h0;
      reg_addr_out  = 8'h00;
      reg_wdata_out = 16'h0000;
      bal_wdata_out = 12'h000;
   end
   // Config refresh write; once released the lines show inverted data.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge mclk_in);
      reg_wr_out    = 1'b1;
      reg_addr_out  = a;
      reg_wdata_out = d;
      @(negedge mclk_in);
      reg_wr_out    = 1'b0;
      reg_addr_out  = ~a;
      reg_wdata_out = ~d;
   endtask : wr
   // Balance enable write, one cycle wide.
   task automatic bal(input logic [11:0] d);
      @(negedge mclk_in);
      bal_wr_out    = 1'b1;
      bal_wdata_out = d;
      @(negedge mclk_in);
      bal_wr_out    = 1'b0;
      bal_wdata_out = ~d;
   endtask : bal
   // One-cycle strobe: read acknowledge slot when sel is 0, status clear when 1.
   task automatic pulse(input logic sel);
      @(negedge mclk_in);
      read_ack_out   = ~sel;
      status_clr_out = sel;
      @(negedge mclk_in);
      read_ack_out   = 1'b0;
      status_clr_out = 1'b0;
   endtask : pulse
endmodule : cbwd_host
`default_nettype wire

// >>> sim/cbwd_top_bench.sv
/*
 Self-checking bench for cbwd_top: power-up, start-up delay, register
 read-back, switch gating, thermal shutdown and reset defaults.
 Assumes cbwd_host as the far side and a 200 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cbwd_top_bench
   import cbwd_pkg::*;
;
   localparam int LIMIT   = 90_000;
   localparam int OSC_CYC = 2 * OSC_HALF_CYC;
   localparam int LO      = (START_DELAY_OSC - 1) * OSC_CYC;
   localparam int HI      = (START_DELAY_OSC + 1) * OSC_CYC;
   logic        mclk_in, rst_in, supply_ok_in, shutdown_input_in;
   logic [7:0]  die_temp_in, reg_addr;
   logic        reg_wr, bal_wr, read_ack, status_clr;
   logic [15:0] reg_wdata, acq_rdata, cfg;
   logic [11:0] bal_wdata, bal_en, drive, b;
   logic        timeout, rflag, reg_en, active, cp_en;
   int          errors = 0;
   int          checks = 0;
   int          cyc    = 0;
   int          n;

   cbwd_host host (.mclk_in(mclk_in), .reg_wr_out(reg_wr), .reg_addr_out(reg_addr),
      .reg_wdata_out(reg_wdata), .bal_wr_out(bal_wr), .bal_wdata_out(bal_wdata),
      .read_ack_out(read_ack), .status_clr_out(status_clr));

   cbwd_top DUT (.mclk_in(mclk_in), .rst_in(rst_in), .supply_ok_in(supply_ok_in),
      .shutdown_input_in(shutdown_input_in), .die_temp_in(die_temp_in),
      .reg_wr_in(reg_wr), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .bal_wr_in(bal_wr), .bal_wdata_in(bal_wdata), .read_ack_in(read_ack),
      .status_clr_in(status_clr), .acq_rdata_out(acq_rdata),
      .balance_switch_enables_out(bal_en), .switch_drive_out(drive),
      .timeout_out(timeout), .reset_occurred_flag_out(rflag),
      .regulator_en_out(reg_en), .logic_active_out(active), .charge_pump_en_out(cp_en));

   // Clock at 200 MHz.
   initial begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end

   // Hang guard: the cycle ceiling counts as a mismatch.
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errors++;
         end_of_test();
      end
   end

   // Verdict and end of run.
   task automatic end_of_test();
      if (errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   // Compare with case equality and count.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cycles(input int k);
      repeat (k) @(negedge mclk_in);
   endtask : cycles

   // Read-back expected before any tick: fields as written, count unchanged.
   function automatic logic [15:0] exp_read(input logic [15:0] c);
      return {c[15:PSEL_LSB], c[CNT_MSB:CNT_LSB], c[7:0]};
   endfunction : exp_read

   // Main sequence; inputs change at falling edges.
   initial begin
      n = $urandom(32'hf162_76d1);
      rst_in = 1'b1;
      supply_ok_in = 1'b0;
      shutdown_input_in = 1'b1;
      die_temp_in = 8'h19;
      cycles(3);
      rst_in = 1'b0;
      chk(acq_rdata, ACQ_CFG_RESET);
      chk({11'h000, timeout, rflag, reg_en, active, cp_en}, 16'h0000);
      supply_ok_in = 1'b1;
      cycles(20);
      chk(16'(reg_en), 16'h0000);
      shutdown_input_in = 1'b0;
      die_temp_in = 8'h96;
      cycles(20);
      chk(16'(reg_en), 16'h0000);
      die_temp_in = 8'h91;
      for (n = 0; n < 4 && reg_en !== 1'b1; n++) @(negedge mclk_in);
      chk(16'(reg_en), 16'h0001);
      for (n = 0; n < LIMIT && active !== 1'b1; n++) @(negedge mclk_in);
      chk(16'(n >= LO && n <= HI), 16'h0001);
      chk({13'h0000, active, cp_en, rflag}, 16'h0007);
      host.pulse(1'b1);
      chk(16'(rflag), 16'h0000);
      // Every prescale code twice; the last arms the timer at count zero.
      for (int i = 0; i < 8; i++) begin
         cfg = 16'($urandom);
         cfg[PSEL_MSB:PSEL_LSB] = 2'(i);
         cfg[CNT_MSB:CNT_LSB] = (i == 7) ? 4'h0 : 4'(1 + $urandom % 15);
         b = 12'($urandom);
         host.wr(ACQ_CFG_OFFSET, cfg);
         host.bal(b);
         host.pulse(1'b0);
         chk(acq_rdata, exp_read(cfg));
         chk({4'h0, drive}, {4'h0, b});
         chk(16'(timeout), 16'h0000);
      end
      host.wr(ACQ_CFG_OFFSET ^ 8'h80, ~cfg);
      host.pulse(1'b0);
      chk(acq_rdata, exp_read(cfg));
      b = 12'($urandom) | 12'h001;
      host.bal(b);
      die_temp_in = 8'h92;
      for (n = 0; n < 8 && (drive !== 12'h000 || reg_en !== 1'b0); n++) @(negedge mclk_in);
      chk({4'h0, drive}, 16'h0000);
      chk({4'h0, bal_en}, {4'h0, b});
      chk(16'(reg_en), 16'h0000);
      die_temp_in = 8'h83;
      cycles(20);
      chk(16'(reg_en), 16'h0000);
      die_temp_in = 8'h82;
      for (n = 0; n < 8 && reg_en !== 1'b1; n++) @(negedge mclk_in);
      chk(16'(reg_en), 16'h0001);
      rst_in = 1'b1;
      cycles(3);
      rst_in = 1'b0;
      chk({4'h0, bal_en}, {4'h0, BAL_EN_RESET});
      chk({11'h000, timeout, rflag, reg_en, active, cp_en}, 16'h0000);
      host.pulse(1'b0);
      chk(acq_rdata, ACQ_CFG_RESET);
      end_of_test();
   end
endmodule : cbwd_top_bench
`default_nettype wire
